// *** hdl/fpdm_top.sv ***
/*
 * Front panel display and menu logic: display modes, status item selection,
 * power-on sequence and five-digit value formatting.
 * Assumes buttons are raw pins, other inputs come from logic on clk_i.
 */
// Behaviour
// - Drive five seven-segment digits and read four pushbuttons for the panel.
// - Mode button steps status, diagnosis, alarm, basic, gain, extension, I/O.
// - Gain, extension and I/O modes reachable only when write-disable allows.
// - In status mode, up or down steps the selected status item.
// - A selected item not yet shown displays its identifying symbol.
// - Set while a symbol shows switches to that item's value.
// - At power-on show configured item's symbol two seconds, then its value.
// - Sixteen items; only the five low decimal digits are shown.
// - Negative motor speed gets a leading minus sign.
// - Other negative values light decimal points of the upper four digits.
// - A stored axis name shows first, then the status display.
// - Set on a cumulative counter value clears that count.
`timescale 1ns/1ps
module fpdm_top #(
    parameter int unsigned POWER_ON_CYCLES = fpdm_pkg::POWER_ON_SYMBOL_CYCLES,
    parameter int unsigned AXIS_CYCLES = fpdm_pkg::AXIS_NAME_CYCLES
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire fpdm_pkg::fpdm_buttons_t buttons_i,
    input wire logic parameter_group_write_disable_i,
    input wire logic [3:0] power_on_status_item_select_i,
    input wire logic axis_name_valid_i,
    input wire fpdm_pkg::fpdm_display_t axis_name_i,
    input wire logic signed [31:0] status_value_i,
    output fpdm_pkg::fpdm_display_t display_o,
    output fpdm_pkg::fpdm_mode_t display_mode_o,
    output logic [3:0] status_item_o,
    output logic count_clear_o
);
    import fpdm_pkg::*;

    typedef enum logic [2:0] {
        ST_BOOT,
        ST_AXIS,
        ST_POWER_SYM,
        ST_SYMBOL,
        ST_VALUE,
        ST_OTHER
    } fpdm_state_t;

    logic rst_s1_reg;
    logic rst_n;
    fpdm_buttons_t btn_s1_reg;
    fpdm_buttons_t btn_s2_reg;
    fpdm_buttons_t btn_s3_reg;
    fpdm_buttons_t evt;
    fpdm_state_t state_reg;
    fpdm_mode_t mode_reg;
    fpdm_mode_t mode_next;
    logic [3:0] sel_reg;
    logic [31:0] timer_reg;
    logic conv_start_reg;
    logic conv_busy;
    logic conv_done;
    logic [19:0] conv_digits;
    logic neg_reg;
    logic conv_fresh_reg;
    logic [31:0] magnitude;
    logic in_status;
    fpdm_display_t display_next;

    // Reset release through two flops
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_s1_reg <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_s1_reg <= 1'b1;
            rst_n <= rst_s1_reg;
        end
    end

    // Button synchronisers and press detection
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            btn_s1_reg <= '0;
            btn_s2_reg <= '0;
            btn_s3_reg <= '0;
        end else begin
            btn_s1_reg <= buttons_i;
            btn_s2_reg <= btn_s1_reg;
            btn_s3_reg <= btn_s2_reg;
        end
    end

    assign evt = btn_s2_reg & ~btn_s3_reg;
    assign in_status = (state_reg == ST_SYMBOL) || (state_reg == ST_VALUE);

    // Next display mode
    always_comb begin
        case (mode_reg)
            MODE_STATUS: mode_next = MODE_DIAG;
            MODE_DIAG: mode_next = MODE_ALARM;
            MODE_ALARM: mode_next = MODE_BASIC;
            MODE_BASIC: mode_next = parameter_group_write_disable_i ? MODE_STATUS : MODE_GAIN;
            MODE_GAIN: mode_next = MODE_EXT;
            MODE_EXT: mode_next = MODE_IO;
            default: mode_next = MODE_STATUS;
        endcase
    end

    // Display mode
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            mode_reg <= MODE_STATUS;
        end else if (evt.mode && (in_status || state_reg == ST_OTHER)) begin
            mode_reg <= mode_next;
        end
    end

    // Screen sequence, item selection and power-on timing
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= ST_BOOT;
            sel_reg <= ITEM_RESET;
            timer_reg <= 32'h0;
        end else begin
            case (state_reg)
                ST_BOOT: begin
                    sel_reg <= power_on_status_item_select_i;
                    if (axis_name_valid_i) begin
                        state_reg <= ST_AXIS;
                        timer_reg <= AXIS_CYCLES - 32'h1;
                    end else begin
                        state_reg <= ST_POWER_SYM;
                        timer_reg <= POWER_ON_CYCLES - 32'h1;
                    end
                end
                ST_AXIS: begin
                    if (timer_reg == 32'h0) begin
                        state_reg <= ST_POWER_SYM;
                        timer_reg <= POWER_ON_CYCLES - 32'h1;
                    end else begin
                        timer_reg <= timer_reg - 32'h1;
                    end
                end
                ST_POWER_SYM: begin
                    if (timer_reg == 32'h0) begin
                        state_reg <= ST_VALUE;
                    end else begin
                        timer_reg <= timer_reg - 32'h1;
                    end
                end
                ST_SYMBOL, ST_VALUE: begin
                    if (evt.mode) begin
                        state_reg <= ST_OTHER;
                    end else if (evt.up) begin
                        sel_reg <= sel_reg + 4'h1;
                        state_reg <= ST_SYMBOL;
                    end else if (evt.down) begin
                        sel_reg <= sel_reg - 4'h1;
                        state_reg <= ST_SYMBOL;
                    end else if (evt.set && state_reg == ST_SYMBOL) begin
                        state_reg <= ST_VALUE;
                    end
                end
                default: begin
                    if (evt.mode && mode_next == MODE_STATUS) begin
                        state_reg <= ST_SYMBOL;
                    end
                end
            endcase
        end
    end

    // Value conversion requests
    assign magnitude = status_value_i[31] ? 32'(-status_value_i) : 32'(status_value_i);
    // Conversions begun before this value screen belong to an earlier item
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            conv_start_reg <= 1'b0;
            neg_reg <= 1'b0;
            conv_fresh_reg <= 1'b0;
        end else begin
            conv_start_reg <= (state_reg == ST_VALUE) && !conv_busy && !conv_start_reg;
            conv_fresh_reg <= (state_reg == ST_VALUE) && (conv_fresh_reg || conv_start_reg);
            if (conv_start_reg) begin
                neg_reg <= status_value_i[31];
            end
        end
    end
    fpdm_bcd u_bcd (
        .clk_i(clk_i),
        .rst_n_i(rst_n),
        .start_i(conv_start_reg),
        .value_i(magnitude),
        .busy_o(conv_busy),
        .done_o(conv_done),
        .digits_o(conv_digits)
    );
    // Panel contents
    always_comb begin
        display_next = '0;
        case (state_reg)
            ST_AXIS: display_next = axis_name_i;
            ST_POWER_SYM, ST_SYMBOL: display_next[4].seg = ITEM_SYM[sel_reg];
            ST_VALUE: begin
                if (conv_done && conv_fresh_reg) begin
                    for (int i = 0; i < 5; i++) begin
                        display_next[i].seg = fpdm_digit_seg(conv_digits[i*4 +: 4]);
                    end
                    if (neg_reg && ITEM_MINUS_MASK[sel_reg]) begin
                        display_next[4].seg = SEG_MINUS;
                    end else if (neg_reg) begin
                        for (int i = 1; i < 5; i++) begin
                            display_next[i].dp = 1'b1;
                        end
                    end
                end else begin
                    display_next = display_o;
                end
            end
            ST_OTHER: display_next[4].seg = MODE_SYM[mode_reg];
            default: display_next = '0;
        endcase
    end

    // Registered outputs
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            display_o <= '0;
            display_mode_o <= MODE_STATUS;
            status_item_o <= ITEM_RESET;
            count_clear_o <= 1'b0;
        end else begin
            display_o <= display_next;
            display_mode_o <= mode_reg;
            status_item_o <= sel_reg;
            count_clear_o <= (state_reg == ST_VALUE) && evt.set && !evt.mode && !evt.up &&
                             !evt.down && ITEM_CLEAR_MASK[sel_reg];
        end
    end

    property p_mode_advance;
        @(posedge clk_i) disable iff (!rst_n)
        (evt.mode && in_status) |=> (mode_reg == MODE_DIAG);
    endproperty
    a_mode_advance: assert property (p_mode_advance)
        else $error("mode press in status did not reach diagnosis");
    property p_group_lock;
        @(posedge clk_i) disable iff (!rst_n)
        (evt.mode && state_reg == ST_OTHER && mode_reg == MODE_BASIC &&
         parameter_group_write_disable_i) |=> (mode_reg == MODE_STATUS && state_reg == ST_SYMBOL);
    endproperty
    a_group_lock: assert property (p_group_lock)
        else $error("locked parameter group was entered");
    property p_mode_wrap;
        @(posedge clk_i) disable iff (!rst_n)
        (evt.mode && state_reg == ST_OTHER && mode_reg == MODE_IO) |=> (mode_reg == MODE_STATUS);
    endproperty
    a_mode_wrap: assert property (p_mode_wrap)
        else $error("mode did not wrap to status");
    property p_item_up;
        @(posedge clk_i) disable iff (!rst_n)
        (in_status && !evt.mode && evt.up) |=>
            (sel_reg == 4'($past(sel_reg) + 4'h1)) && state_reg == ST_SYMBOL ##1
            (status_item_o == $past(sel_reg));
    endproperty
    a_item_up: assert property (p_item_up)
        else $error("up press did not step the item");
    property p_item_wrap_down;
        @(posedge clk_i) disable iff (!rst_n)
        (in_status && !evt.mode && !evt.up && evt.down && sel_reg == ITEM_RESET) |=>
            (sel_reg == ITEM_LAST);
    endproperty
    a_item_wrap_down: assert property (p_item_wrap_down)
        else $error("down press at first item did not wrap");
    property p_symbol_shown;
        @(posedge clk_i) disable iff (!rst_n)
        (state_reg == ST_SYMBOL) |=> (display_o[4].seg == ITEM_SYM[$past(sel_reg)]);
    endproperty
    a_symbol_shown: assert property (p_symbol_shown)
        else $error("symbol of selected item not shown");
    property p_set_shows_value;
        @(posedge clk_i) disable iff (!rst_n)
        (state_reg == ST_SYMBOL && evt.set && !evt.mode && !evt.up && !evt.down) |=>
            (state_reg == ST_VALUE) ##[1:40] conv_done;
    endproperty
    a_set_shows_value: assert property (p_set_shows_value)
        else $error("set press did not lead to a value");
    property p_power_on_end;
        @(posedge clk_i) disable iff (!rst_n)
        (state_reg == ST_POWER_SYM && timer_reg == 32'h0) |=> (state_reg == ST_VALUE);
    endproperty
    a_power_on_end: assert property (p_power_on_end)
        else $error("power-on symbol did not end in value");
    property p_power_on_item;
        @(posedge clk_i) disable iff (!rst_n)
        (state_reg == ST_BOOT) |=> (sel_reg == $past(power_on_status_item_select_i));
    endproperty
    a_power_on_item: assert property (p_power_on_item)
        else $error("power-on item not taken");
    property p_low_digit;
        @(posedge clk_i) disable iff (!rst_n)
        (conv_done && conv_fresh_reg && state_reg == ST_VALUE) |=>
            (display_o[0].seg == fpdm_digit_seg($past(conv_digits[3:0])));
    endproperty
    a_low_digit: assert property (p_low_digit)
        else $error("low digit does not match value");
    property p_minus_sign;
        @(posedge clk_i) disable iff (!rst_n)
        (conv_done && conv_fresh_reg && state_reg == ST_VALUE && neg_reg &&
         ITEM_MINUS_MASK[sel_reg]) |=>
            (display_o[4].seg == SEG_MINUS && !display_o[1].dp);
    endproperty
    a_minus_sign: assert property (p_minus_sign)
        else $error("reverse speed lacks minus sign");
    property p_neg_points;
        @(posedge clk_i) disable iff (!rst_n)
        (conv_done && conv_fresh_reg && state_reg == ST_VALUE && neg_reg &&
         !ITEM_MINUS_MASK[sel_reg]) |=>
            (display_o[4].dp && display_o[3].dp && display_o[2].dp && display_o[1].dp &&
             !display_o[0].dp);
    endproperty
    a_neg_points: assert property (p_neg_points)
        else $error("negative value lacks decimal points");
    property p_axis_first;
        @(posedge clk_i) disable iff (!rst_n)
        (state_reg == ST_BOOT && axis_name_valid_i) |=> (state_reg == ST_AXIS) ##1
            (display_o == $past(axis_name_i));
    endproperty
    a_axis_first: assert property (p_axis_first)
        else $error("stored axis name not shown first");
    property p_count_clear;
        @(posedge clk_i) disable iff (!rst_n)
        (state_reg == ST_VALUE && evt.set && !evt.mode && !evt.up && !evt.down &&
         ITEM_CLEAR_MASK[sel_reg]) |=> count_clear_o ##1 !count_clear_o;
    endproperty
    a_count_clear: assert property (p_count_clear)
        else $error("counter clear pulse missing");
endmodule // fpdm_top

// *** hdl/fpdm_pkg.sv ***
/*
 * Shared types and constants of the front panel display and menu block.
 * Assumes a 40 MHz system clock and a five-digit seven-segment panel.
 */
package fpdm_pkg;

    // Segment order within a digit: g f e d c b a
    typedef struct packed {
        logic dp;
        logic [6:0] seg;
    } fpdm_digit_t;

    typedef fpdm_digit_t [4:0] fpdm_display_t;

    typedef struct packed {
        logic mode;
        logic up;
        logic down;
        logic set;
    } fpdm_buttons_t;

    typedef enum logic [2:0] {
        MODE_STATUS,
        MODE_DIAG,
        MODE_ALARM,
        MODE_BASIC,
        MODE_GAIN,
        MODE_EXT,
        MODE_IO
    } fpdm_mode_t;

    // Timing
    localparam int unsigned CLK_HZ = 40_000_000;
    localparam int unsigned POWER_ON_SYMBOL_MS = 2000;
    localparam int unsigned AXIS_NAME_MS = 2000;
    localparam int unsigned POWER_ON_SYMBOL_CYCLES = CLK_HZ / 1000 * POWER_ON_SYMBOL_MS;
    localparam int unsigned AXIS_NAME_CYCLES = CLK_HZ / 1000 * AXIS_NAME_MS;

    // Item table
    localparam int unsigned ITEM_COUNT = 16;
    localparam logic [3:0] ITEM_LAST = 4'hf;
    localparam logic [3:0] ITEM_RESET = 4'h0;
    localparam logic [15:0] ITEM_MINUS_MASK = 16'h0002;
    localparam logic [15:0] ITEM_CLEAR_MASK = 16'h0009;
    localparam logic [15:0][6:0] ITEM_SYM = {
        7'h78, 7'h76, 7'h77, 7'h5c, 7'h74, 7'h5e, 7'h7c, 7'h1e,
        7'h38, 7'h3e, 7'h71, 7'h54, 7'h73, 7'h79, 7'h50, 7'h39
    };
    localparam logic [6:0][6:0] MODE_SYM = {
        7'h30, 7'h79, 7'h3d, 7'h73, 7'h77, 7'h5e, 7'h6d
    };
    localparam logic [6:0] SEG_MINUS = 7'h40;
    localparam logic [6:0] SEG_BLANK = 7'h00;

    // Binary to decimal conversion
    localparam logic [5:0] CONV_STEPS = 6'h20;

    function automatic logic [6:0] fpdm_digit_seg(input logic [3:0] d);
        case (d)
            4'h0: fpdm_digit_seg = 7'h3f;
            4'h1: fpdm_digit_seg = 7'h06;
            4'h2: fpdm_digit_seg = 7'h5b;
            4'h3: fpdm_digit_seg = 7'h4f;
            4'h4: fpdm_digit_seg = 7'h66;
            4'h5: fpdm_digit_seg = 7'h6d;
            4'h6: fpdm_digit_seg = 7'h7d;
            4'h7: fpdm_digit_seg = 7'h07;
            4'h8: fpdm_digit_seg = 7'h7f;
            4'h9: fpdm_digit_seg = 7'h6f;
            default: fpdm_digit_seg = 7'h00;
        endcase
    endfunction

endpackage

// *** hdl/fpdm_bcd.sv ***
/*
 * Serial binary to decimal converter keeping the five low decimal digits.
 * Assumes start is a one-cycle pulse given only while not busy.
 */
`timescale 1ns/1ps
module fpdm_bcd (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic start_i,
    input wire logic [31:0] value_i,
    output logic busy_o,
    output logic done_o,
    output logic [19:0] digits_o
);
    import fpdm_pkg::*;

    logic [31:0] bin_reg;
    logic [19:0] bcd_reg;
    logic [19:0] adj;
    logic [5:0] cnt_reg;

    // Add three to each digit of five or more before the shift
    for (genvar g = 0; g < 5; g++) begin : g_adj
        assign adj[g*4 +: 4] = (bcd_reg[g*4 +: 4] >= 4'h5) ?
                               4'(bcd_reg[g*4 +: 4] + 4'h3) : bcd_reg[g*4 +: 4];
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            bin_reg <= 32'h0;
            bcd_reg <= 20'h0;
            cnt_reg <= 6'h0;
            busy_o <= 1'b0;
            done_o <= 1'b0;
        end else begin
            done_o <= 1'b0;
            if (start_i) begin
                bin_reg <= value_i;
                bcd_reg <= 20'h0;
                cnt_reg <= CONV_STEPS;
                busy_o <= 1'b1;
            end else if (busy_o) begin
                bcd_reg <= {adj[18:0], bin_reg[31]};
                bin_reg <= {bin_reg[30:0], 1'b0};
                cnt_reg <= cnt_reg - 6'h1;
                if (cnt_reg == 6'h1) begin
                    busy_o <= 1'b0;
                    done_o <= 1'b1;
                end
            end
        end
    end

    assign digits_o = bcd_reg;

endmodule // fpdm_bcd

// *** dv/fpdm_operator.sv ***
/*
 * Operator model: presses one front panel button at a time.
 * Assumes the caller waits for the task to return before the next press.
 */
`timescale 1ns/1ps
module fpdm_operator (
    input wire logic clk_i,
    output fpdm_pkg::fpdm_buttons_t buttons_o
);
    import fpdm_pkg::*;

    initial buttons_o = '0;

    // Button 0 mode, 1 up, 2 down, 3 set
    // Held three cycles, then released three cycles so the next press is a new edge
    task automatic press(input int unsigned which);
        @(posedge clk_i);
        buttons_o <= fpdm_buttons_t'(4'h8 >> which);
        repeat (3) @(posedge clk_i);
        buttons_o <= '0;
        repeat (3) @(posedge clk_i);
    endtask
endmodule // fpdm_operator

// *** dv/front_panel_display_menu_test.sv ***
/*
 * Self-checking bench of the front panel display and menu block.
 * Assumes shortened power-on and axis name times set by parameters.
 */
`timescale 1ns/1ps
module front_panel_display_menu_test;
    import fpdm_pkg::*;

    localparam int unsigned PON = 20;
    localparam int unsigned AXC = 10;
    localparam logic [9:0][6:0] SEGS = {
        7'h6f, 7'h7f, 7'h07, 7'h7d, 7'h6d, 7'h66, 7'h4f, 7'h5b, 7'h06, 7'h3f
    };
    localparam fpdm_display_t AXIS = 40'h77_37_3e_06_5e;

    logic clk = 1'b0;
    logic rst_n = 1'b0;
    fpdm_buttons_t buttons;
    logic lock = 1'b1;
    logic signed [31:0] value = 32'sd123456;
    fpdm_display_t display;
    fpdm_mode_t mode;
    logic [3:0] item;
    logic clr;
    int n_errors = 0;
    int n_compared = 0;
    int n_clr = 0;

    always #12.5 clk = ~clk;

    fpdm_operator op (
        .clk_i(clk),
        .buttons_o(buttons)
    );

    fpdm_top #(
        .POWER_ON_CYCLES(PON),
        .AXIS_CYCLES(AXC)
    ) uut (
        .clk_i(clk),
        .rst_n_i(rst_n),
        .buttons_i(buttons),
        .parameter_group_write_disable_i(lock),
        .power_on_status_item_select_i(4'hf),
        .axis_name_valid_i(1'b1),
        .axis_name_i(AXIS),
        .status_value_i(value),
        .display_o(display),
        .display_mode_o(mode),
        .status_item_o(item),
        .count_clear_o(clr)
    );

    always @(posedge clk) begin
        if (clr === 1'b1) begin
            n_clr <= n_clr + 1;
        end
    end

    task automatic complete_run;
        $display("compared %0d errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [39:0] exp, input logic [39:0] got);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    function automatic fpdm_display_t one_digit(input logic [6:0] s);
        return {1'b0, s, 32'h0};
    endfunction

    function automatic fpdm_display_t exp_val(input int v, input int it);
        fpdm_display_t d;
        int a;
        d = '0;
        a = (v < 0 ? -v : v) % 100000;
        for (int i = 0; i < 5; i++) begin
            d[i].seg = SEGS[a % 10];
            a = a / 10;
        end
        if (v < 0 && it == 1) begin
            d[4].seg = SEG_MINUS;
        end else if (v < 0) begin
            for (int i = 1; i < 5; i++) begin
                d[i].dp = 1'b1;
            end
        end
        return d;
    endfunction

    // Bounded wait for an expected display image
    task automatic wait_disp(input string what, input fpdm_display_t exp, input int lim);
        int k;
        k = 0;
        while (display !== exp && k < lim) begin
            @(posedge clk);
            #1;
            k++;
        end
        check(what, exp, display);
        if (display !== exp) begin
            complete_run();
        end
    endtask

    task automatic push(input int unsigned w);
        op.press(w);
        #1;
    endtask

    task automatic set_value(input int v);
        @(posedge clk);
        value <= v;
    endtask

    task automatic t_power_on;
        wait_disp("axis name", AXIS, AXC);
        wait_disp("power-on symbol", one_digit(ITEM_SYM[15]), AXC + 4);
        repeat (PON - 3) @(posedge clk);
        #1;
        check("symbol held", one_digit(ITEM_SYM[15]), display);
        wait_disp("power-on value", exp_val(123456, 15), PON + 80);
        check("power-on item", 40'(4'hf), 40'(item));
    endtask

    task automatic t_step;
        push(1);
        check("item up wrap", 40'(4'h0), 40'(item));
        wait_disp("symbol 0", one_digit(ITEM_SYM[0]), 4);
        push(2);
        check("item down wrap", 40'(4'hf), 40'(item));
        push(2);
        check("item down", 40'(4'he), 40'(item));
        wait_disp("symbol 14", one_digit(ITEM_SYM[14]), 4);
    endtask

    task automatic t_values;
        for (int i = 0; i < 3; i++) begin
            push(1);
        end
        check("item 1", 40'(4'h1), 40'(item));
        set_value(-3000);
        push(3);
        wait_disp("minus value", exp_val(-3000, 1), 80);
        push(1);
        wait_disp("symbol 2", one_digit(ITEM_SYM[2]), 4);
        set_value(-12566);
        push(3);
        repeat (25) @(posedge clk);
        #1;
        check("held until fresh", one_digit(ITEM_SYM[2]), display);
        wait_disp("dp value", exp_val(-12566, 2), 80);
        push(2);
        push(2);
        set_value(123456);
        push(3);
        wait_disp("low five digits", exp_val(123456, 0), 80);
        check("no clear yet", 40'(0), 40'(n_clr));
        push(3);
        check("clear pulse", 40'(1), 40'(n_clr));
        check("clear item", 40'(4'h0), 40'(item));
    endtask

    task automatic t_modes;
        fpdm_mode_t seq [8];
        seq = '{MODE_DIAG, MODE_ALARM, MODE_BASIC, MODE_STATUS,
                MODE_GAIN, MODE_EXT, MODE_IO, MODE_STATUS};
        for (int i = 0; i < 4; i++) begin
            push(0);
            check("locked mode", 40'(seq[i]), 40'(mode));
            if (i == 0) begin
                push(1);
                check("up ignored", 40'(4'h0), 40'(item));
            end
        end
        wait_disp("back to symbol", one_digit(ITEM_SYM[0]), 4);
        @(posedge clk);
        lock <= 1'b0;
        for (int i = 0; i < 7; i++) begin
            push(0);
            check("open mode", 40'(i < 6 ? seq[i < 3 ? i : i + 1] : MODE_STATUS),
                  40'(mode));
            if (i < 6) begin
                check("mode symbol", 40'(one_digit(MODE_SYM[seq[i < 3 ? i : i + 1]])),
                      40'(display));
            end
        end
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        complete_run();
    end

    initial begin
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        t_power_on();
        t_step();
        t_values();
        t_modes();
        complete_run();
    end
endmodule // front_panel_display_menu_test
